/* vcoc_pkg.sv */
// Constants for the channel one resource control register
package vcoc_pkg;
   localparam logic [11:0] CTRL_OFFSET = 12'h120;
   localparam int ON_BIT = 31;
   localparam int ID_HI = 26;
   localparam int ID_LO = 24;
   localparam int MAP_HI = 7;
   localparam int MAP_LO = 1;
   localparam int ZERO_BIT = 0;
   localparam logic ON_RESET = 1'h0;
   localparam logic [2:0] ID_RESET = 3'h1;
   localparam logic [6:0] MAP_RESET = 7'h00;
endpackage

/* vcoc_ctrl.sv */
// Channel one resource control register bank
// How it works
// - Bit 31 is a read/write channel enable that resets to 0.
// - Bits 26:24 hold a read/write channel identifier that resets to 001.
// - Identifier writes are ignored while the channel is enabled.
// - Bits 7:1 are a read/write traffic class map that resets to zero.
// - Any number of map bits may be set at once, each mapping its class.
// - Bit 0 always reads zero since class zero never maps to this channel.
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module vcoc_ctrl
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Register port
   input wire logic [11:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // Channel state toward the link logic
   output logic channel_one_on,
   output logic [2:0] channel_one_identifier,
   output logic [7:0] class_to_channel_one_map
);
   // Stored fields and their next values
   logic on_q;
   logic on_d;
   logic [2:0] id_q;
   logic [2:0] id_d;
   logic [6:0] map_q;
   wire [6:0] map_d;
   // Read word and its next value
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   // Address decode, only the one control word is mapped
   wire hit = (addr == vcoc_pkg::CTRL_OFFSET);
   wire wr_hit = wr && hit;
   wire rd_hit = rd && hit;
   // Old enable gates the id, so a write that turns the channel on still takes its id
   wire id_wr_ok = wr_hit && !on_q;

   // Write data split into fields; reserved bits never reach a flop
   wire on_wdata = wdata[vcoc_pkg::ON_BIT];
   wire [2:0] id_wdata = wdata[vcoc_pkg::ID_HI:vcoc_pkg::ID_LO];
   wire [6:0] map_wdata = wdata[vcoc_pkg::MAP_HI:vcoc_pkg::MAP_LO];

   // Next enable and identifier; a zero id is stored as written, only software keeps it non-zero
   assign on_d = wr_hit ? on_wdata : on_q;
   assign id_d = id_wr_ok ? id_wdata : id_q;

   // Map next value, one slice per traffic class, so any mix of classes can be mapped
   generate
      for (genvar n = 0; n <= vcoc_pkg::MAP_HI - vcoc_pkg::MAP_LO; n++)
      begin : g_map
         assign map_d[n] = wr_hit ? map_wdata[n] : map_q[n];
         // Each class bit follows its own written bit
         a_map_bit: assert property (@(posedge clock) disable iff (rst)
            wr_hit |=> map_q[n] == $past(map_wdata[n]))
            else $error("class map bit did not take written value");
      end
   endgenerate

   // Register image; reserved bits and class zero are tied low
   wire [31:0] image = {on_q, 4'h0, id_q, 16'h0000, map_q, 1'h0};
   // Read word stands one cycle, zero otherwise so no stale word lingers on the port
   assign rdata_d = rd_hit ? image : 32'h00000000;

   // Enable flop; the far end model copies it one cycle later,
   // nothing here waits for the link
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         on_q <= vcoc_pkg::ON_RESET;
      end
      else
      begin
         on_q <= on_d;
      end
   end

   // Identifier flop
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         id_q <= vcoc_pkg::ID_RESET;
      end
      else
      begin
         id_q <= id_d;
      end
   end

   // Map flop
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         map_q <= vcoc_pkg::MAP_RESET;
      end
      else
      begin
         map_q <= map_d;
      end
   end

   // Read data flop; cleared in every cycle without a read
   // so a word stays on the port only while its read repeats
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         rdata_q <= 32'h00000000;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   // Outputs straight from the flops
   assign rdata = rdata_q;
   assign channel_one_on = on_q;
   assign channel_one_identifier = id_q;
   assign class_to_channel_one_map = {map_q, 1'h0};

   // Identifier frozen while enabled
   a_id_frozen: assert property (@(posedge clock) disable iff (rst)
      $past(on_q) |-> $stable(id_q))
      else $error("identifier changed while enabled");

   // Enable follows written bit
   a_on_write: assert property (@(posedge clock) disable iff (rst)
      wr_hit |=> on_q == $past(wdata[vcoc_pkg::ON_BIT]))
      else $error("enable did not take written value");

   // Map follows written bits
   a_map_write: assert property (@(posedge clock) disable iff (rst)
      wr_hit |=> map_q == $past(wdata[vcoc_pkg::MAP_HI:vcoc_pkg::MAP_LO]))
      else $error("map did not take written value");

   // Identifier takes write when disabled
   a_id_write: assert property (@(posedge clock) disable iff (rst)
      (wr_hit && !on_q) |=> id_q == $past(wdata[vcoc_pkg::ID_HI:vcoc_pkg::ID_LO]))
      else $error("identifier write lost");

   // Write that enables still takes its identifier
   a_enable_id_take: assert property (@(posedge clock) disable iff (rst)
      (wr_hit && !on_q && wdata[vcoc_pkg::ON_BIT]) |=> on_q && (id_q == $past(id_wdata)))
      else $error("enabling write lost identifier");

   // Identifier write ignored while enabled
   a_id_on_write: assert property (@(posedge clock) disable iff (rst)
      (wr_hit && on_q) |=> id_q == $past(id_q))
      else $error("identifier taken while enabled");

   // Reserved bits and bit zero read zero
   a_rsvd_zero: assert property (@(posedge clock) disable iff (rst)
      (rdata[30:27] == 4'h0) && (rdata[23:8] == 16'h0000) && !rdata[0])
      else $error("reserved bit read non-zero");

   // Class zero bit of the read word stays low
   a_zero_bit: assert property (@(posedge clock) disable iff (rst)
      !rdata[vcoc_pkg::ZERO_BIT])
      else $error("class zero bit read high");

   // Class zero never mapped
   a_class_zero: assert property (@(posedge clock) disable iff (rst)
      !class_to_channel_one_map[0])
      else $error("class zero mapped to channel one");

   // Read returns register image one cycle later
   a_read_data: assert property (@(posedge clock) disable iff (rst)
      rd_hit |=> rdata == {$past(on_q), 4'h0, $past(id_q), 16'h0000, $past(map_q), 1'h0})
      else $error("read data mismatch");

   // Read word carries the enable
   a_read_on: assert property (@(posedge clock) disable iff (rst)
      rd_hit |=> rdata[vcoc_pkg::ON_BIT] == $past(on_q))
      else $error("read enable bit mismatch");

   // Read word carries the identifier
   a_read_id: assert property (@(posedge clock) disable iff (rst)
      rd_hit |=> rdata[vcoc_pkg::ID_HI:vcoc_pkg::ID_LO] == $past(id_q))
      else $error("read identifier mismatch");

   // Read word carries the whole map
   a_read_map: assert property (@(posedge clock) disable iff (rst)
      rd_hit |=> rdata[vcoc_pkg::MAP_HI:vcoc_pkg::MAP_LO] == $past(map_q))
      else $error("read map mismatch");

   // Read port idles at zero, unmapped reads included
   a_rdata_idle: assert property (@(posedge clock) disable iff (rst)
      !rd_hit |=> rdata == 32'h00000000)
      else $error("read port not zero outside a read");

   // Writes to other addresses leave the state alone
   a_foreign_write: assert property (@(posedge clock) disable iff (rst)
      (wr && !hit) |=> $stable(on_q) && $stable(id_q) && $stable(map_q))
      else $error("state changed by a foreign write");

   // No write keeps all state
   a_hold_state: assert property (@(posedge clock) disable iff (rst)
      !wr_hit |=> $stable(on_q) && $stable(map_q) && $stable(id_q))
      else $error("state changed without a write");

   // State leaves reset at its reset values
   a_reset_state: assert property (@(posedge clock)
      $fell(rst) |-> (on_q == vcoc_pkg::ON_RESET) && (id_q == vcoc_pkg::ID_RESET)
         && (map_q == vcoc_pkg::MAP_RESET))
      else $error("state not at reset values after reset");
endmodule
`default_nettype wire

/* vcoc_far.sv */
// Link partner model that mirrors the channel enable
`timescale 1ns/1ns
`default_nettype none
module vcoc_far
(
   // Clock, reset and near-end enable
   input wire logic clock,
   input wire logic rst,
   input wire logic near_on,
   // Far-end enable, set and cleared one cycle behind
   output logic peer_on_q
);
   // Far end copies the near enable one cycle later, with no software step
   always_ff @(posedge clock or posedge rst)
      if (rst) peer_on_q <= 1'h0;
      else peer_on_q <= near_on;
endmodule
`default_nettype wire

/* tb_virtual_channel_one_control.sv */
// Random and corner tests of the channel one control register
`timescale 1ns/1ns
`default_nettype none
module tb_virtual_channel_one_control;
   logic clock = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, on, peer;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata, m = 32'h01000000, s = 32'h0A9733BA;
   logic [2:0] id;
   logic [7:0] map;
   int bad_count = 0, total_checks = 0;
   vcoc_ctrl i_dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .channel_one_on(on), .channel_one_identifier(id), .class_to_channel_one_map(map));
   vcoc_far i_far (.clock(clock), .rst(rst), .near_on(on), .peer_on_q(peer));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   // Expected word after a write; id held while the channel was on
   function automatic logic [31:0] nx(input logic [31:0] o, input logic [31:0] d);
      return {d[31], 4'h0, o[31] ? o[26:24] : d[26:24], 16'h0000, d[7:1], 1'h0};
   endfunction
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // One strobe cycle; read data is settled after the return
   task automatic op(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'h0;
      rd <= 1'h0;
      #1;
   endtask
   task automatic step(input logic [11:0] a, input logic [31:0] d);
      op(1'h1, a, d);
      if (a == vcoc_pkg::CTRL_OFFSET) m = nx(m, d);
      op(1'h0, 12'h120, 32'h0);
      chk("rdata", rdata, m);
      chk("state", {on, 4'h0, id, 16'h0000, map}, m);
      chk("peer", {31'h0, peer}, {31'h0, m[31]});
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial forever #10 clock = ~clock;
   // Watchdog well past the expected run length
   initial
   begin
      #100000;
      bad_count++;
      results();
   end
   initial
   begin
      repeat (10) @(posedge clock);
      rst <= 1'h0;
      step(12'h124, 32'hFFFFFFFF);
      step(12'h120, 32'h82000006);
      step(12'h120, 32'h03000000);
      step(12'h120, 32'h7FFFFFFF);
      repeat (40)
      begin
         s = xs(s);
         step(12'h120, (s[26:24] == 3'h0) ? (s | 32'h01000000) : s);
      end
      op(1'h0, 12'h124, 32'h0);
      chk("unmapped", rdata, 32'h0);
      results();
   end
endmodule
`default_nettype wire
